//--- accel_output_register_readout.sv
// Purpose: Read-side register bank with auto-increment pointer, served on the link clock.
// Assumes: The serial front end decodes frames into start, read and write strobes that are
//          synchronous to I_LINK_CLK; the sensor core drives its samples on I_SYS_CLK.
// Notes:   Sample data crosses to the link domain by a toggle handshake on a whole bundle.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////////////////////////
module accel_output_register_readout (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_LINK_CLK,
  input  wire logic        i_LINK_START,
  input  wire logic [7:0]  i_LINK_ADDR,
  input  wire logic        i_LINK_RD,
  input  wire logic        i_LINK_WR,
  input  wire logic [7:0]  i_LINK_WDATA,
  input  wire logic [7:0]  i_EVENT_FLAGS,
  input  wire logic [7:0]  i_TEMPERATURE,
  input  wire logic [11:0] i_VECTOR_MAGNITUDE,
  input  wire logic [11:0] i_X_CURRENT,
  input  wire logic [11:0] i_Y_CURRENT,
  input  wire logic [11:0] i_Z_CURRENT,
  input  wire logic        i_STORE_WATERMARK,
  input  wire logic        i_STORE_OVERFLOW,
  input  wire logic [5:0]  i_STORE_COUNT,
  input  wire logic [11:0] i_STORED_X,
  output logic      [7:0]  o_LINK_RDATA,
  output logic      [7:0]  o_LINK_POINTER,
  output logic      [7:0]  o_SENSOR_CONFIG_SECOND,
  output logic      [7:0]  o_SENSOR_CONFIG_FIFTH
);

  // Aliases for the package constants used inside the functions below; they are
  // declared first so that every case label refers to a name already known.
  localparam logic [7:0] ADDR_EVENT_FLAG_STATUS      = readout_pkg::ADDR_EVENT_FLAG_STATUS;
  localparam logic [7:0] ADDR_TEMPERATURE_VALUE      = readout_pkg::ADDR_TEMPERATURE_VALUE;
  localparam logic [7:0] ADDR_MAGNITUDE_LOW_ADDRESS  = readout_pkg::ADDR_MAGNITUDE_LOW_ADDRESS;
  localparam logic [7:0] ADDR_MAGNITUDE_HIGH_ADDRESS = readout_pkg::ADDR_MAGNITUDE_HIGH_ADDRESS;
  localparam logic [7:0] ADDR_X_CURRENT_LOW_ADDRESS  = readout_pkg::ADDR_X_CURRENT_LOW_ADDRESS;
  localparam logic [7:0] ADDR_X_CURRENT_HIGH_ADDRESS = readout_pkg::ADDR_X_CURRENT_HIGH_ADDRESS;
  localparam logic [7:0] ADDR_Y_CURRENT_LOW_ADDRESS  = readout_pkg::ADDR_Y_CURRENT_LOW_ADDRESS;
  localparam logic [7:0] ADDR_Y_CURRENT_HIGH_ADDRESS = readout_pkg::ADDR_Y_CURRENT_HIGH_ADDRESS;
  localparam logic [7:0] ADDR_Z_CURRENT_LOW_ADDRESS  = readout_pkg::ADDR_Z_CURRENT_LOW_ADDRESS;
  localparam logic [7:0] ADDR_Z_CURRENT_HIGH_ADDRESS = readout_pkg::ADDR_Z_CURRENT_HIGH_ADDRESS;
  localparam logic [7:0] ADDR_FACTORY_RESERVED_ONE   = readout_pkg::ADDR_FACTORY_RESERVED_ONE;
  localparam logic [7:0] ADDR_STORED_X_LOW_ADDRESS   = readout_pkg::ADDR_STORED_X_LOW_ADDRESS;
  localparam logic [7:0] ADDR_STORED_X_HIGH_ADDRESS  = readout_pkg::ADDR_STORED_X_HIGH_ADDRESS;

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  //////////////////////////////////////////////////////////////////////////////////////////////////

  // Byte placed at the lower address of a 12-bit pair.
  function automatic logic [7:0] low_addr_byte(input logic [11:0] v, input logic be);
    logic [7:0] r;
    r = be ? v[11:4] : v[7:0];
    return r;
  endfunction

  // Byte placed at the higher address of a 12-bit pair; unused upper nibble reads zero.
  function automatic logic [7:0] high_addr_byte(input logic [11:0] v, input logic be);
    logic [7:0] r;
    r = be ? {4'h0, v[3:0]} : {4'h0, v[11:8]};
    return r;
  endfunction

  // Raw step of the pointer before any skipping is applied.
  function automatic logic [7:0] raw_step(input logic [7:0] a, input logic fast);
    logic [7:0] r;
    r = a + 8'h01;
    if (fast) begin
      if ((a >= ADDR_MAGNITUDE_LOW_ADDRESS) && (a <= ADDR_Z_CURRENT_HIGH_ADDRESS)) begin
        // Jump to the low byte of the following pair; past Z the read wraps.
        r = (a | 8'h01) + 8'h01;
        if (r == ADDR_FACTORY_RESERVED_ONE) begin
          r = ADDR_EVENT_FLAG_STATUS;
        end
      end else if (a >= ADDR_STORED_X_LOW_ADDRESS) begin
        // Stored samples also step by whole pairs.
        r = (a | 8'h01) + 8'h01;
      end
    end
    return r;
  endfunction

  // True when the address is currently left out of the auto-increment walk.
  function automatic logic is_skipped(input logic [7:0] a,
                                      input logic [7:0] cfg2,
                                      input logic [7:0] cfg5);
    logic r;
    r = 1'b0;
    case (a)
      ADDR_TEMPERATURE_VALUE: begin
        r = ~cfg2[readout_pkg::BIT_TEMPERATURE_INCLUDE_BIT];
      end
      ADDR_MAGNITUDE_LOW_ADDRESS, ADDR_MAGNITUDE_HIGH_ADDRESS: begin
        r = ~cfg5[readout_pkg::BIT_MAGNITUDE_ENABLE_BIT];
      end
      ADDR_X_CURRENT_LOW_ADDRESS, ADDR_X_CURRENT_HIGH_ADDRESS,
      ADDR_STORED_X_LOW_ADDRESS, ADDR_STORED_X_HIGH_ADDRESS: begin
        r = cfg5[readout_pkg::BIT_X_AXIS_DISABLE_BIT];
      end
      ADDR_Y_CURRENT_LOW_ADDRESS, ADDR_Y_CURRENT_HIGH_ADDRESS: begin
        r = cfg5[readout_pkg::BIT_Y_AXIS_DISABLE_BIT];
      end
      ADDR_Z_CURRENT_LOW_ADDRESS, ADDR_Z_CURRENT_HIGH_ADDRESS: begin
        r = cfg5[readout_pkg::BIT_Z_AXIS_DISABLE_BIT];
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction

  // Next pointer after a read; the bounded loop keeps the logic finite.
  function automatic logic [7:0] next_pointer(input logic [7:0] a,
                                              input logic [7:0] cfg2,
                                              input logic [7:0] cfg5);
    logic [7:0] c;
    logic       fast;
    fast = cfg2[readout_pkg::BIT_FAST_READ_ENABLE];
    c = raw_step(a, fast);
    for (int i = 0; i < readout_pkg::SKIP_PASSES; i++) begin
      if (is_skipped(c, cfg2, cfg5)) begin
        c = raw_step(c, fast);
      end
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // System domain: capture the sensor bundle and offer it to the link side.
  //////////////////////////////////////////////////////////////////////////////////////////////////

  readout_pkg::sample_bundle_t live_bundle;   // Current core outputs, same clock as I_SYS_CLK.
  readout_pkg::sample_bundle_t hold_q;        // Bundle held still while the link copies it.
  logic                        offer_q;       // Toggles each time a new bundle is offered.
  logic                        taken_q;       // Link-domain flag: last offer copied.
  logic                        taken_s1_q;    // First stage of the acknowledge synchroniser.
  logic                        taken_s2_q;    // Second stage, safe to read.

  // Gather the core outputs into one carrier word.
  always_comb begin
    live_bundle.event_flags      = i_EVENT_FLAGS;
    live_bundle.temperature      = i_TEMPERATURE;
    live_bundle.vector_magnitude = i_VECTOR_MAGNITUDE;
    live_bundle.x_current        = i_X_CURRENT;
    live_bundle.y_current        = i_Y_CURRENT;
    live_bundle.z_current        = i_Z_CURRENT;
    live_bundle.store_watermark  = i_STORE_WATERMARK;
    live_bundle.store_overflow   = i_STORE_OVERFLOW;
    live_bundle.store_count      = i_STORE_COUNT;
    live_bundle.stored_x         = i_STORED_X;
  end

  // Constant reset image, packed in field order. It is a constant rather than a
  // signal so that the asynchronous reset branch below loads nothing but constants.
  // event flag reset value
  localparam readout_pkg::sample_bundle_t RESET_BUNDLE = {
    readout_pkg::RST_EVENT_FLAG_STATUS,    // Event flags.
    8'h00,                                 // Temperature.
    12'h000,                               // Vector magnitude.
    12'h000,                               // X sample.
    12'h000,                               // Y sample.
    12'h000,                               // Z sample.
    readout_pkg::RST_SAMPLE_STORE_STATUS,  // Watermark, overflow and count.
    12'h000                                // Stored X sample.
  };

  // Bring the link side's acknowledge into the system domain.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      taken_s1_q <= 1'b0;
      taken_s2_q <= 1'b0;
    end else begin
      taken_s1_q <= taken_q;
      taken_s2_q <= taken_s1_q;
    end
  end

  // Offer a fresh bundle only after the previous one was taken, so hold_q never
  // changes while the link side may be copying it.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      hold_q  <= '0;
      offer_q <= 1'b0;
    end else if (taken_s2_q == offer_q) begin
      hold_q  <= live_bundle;
      offer_q <= ~offer_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Link domain: take bundles, hold configuration, serve reads.
  //////////////////////////////////////////////////////////////////////////////////////////////////

  readout_pkg::sample_bundle_t shadow_q;   // Copy the link side reads from.
  logic                        offer_s1_q; // First stage of the offer synchroniser.
  logic                        offer_s2_q; // Second stage, safe to read.
  logic [7:0]                  cfg2_q;     // Second sensor configuration register.
  logic [7:0]                  cfg5_q;     // Fifth sensor configuration register.
  logic [7:0]                  pointer_q;  // Register pointer of the current frame.
  logic [7:0]                  rdata_q;    // Byte last returned to the front end.
  logic [7:0]                  read_byte;  // Byte addressed by the pointer now.
  logic                        be_sel;     // Endianness select, 1 puts the upper bits first.

  assign be_sel = cfg2_q[readout_pkg::BIT_ENDIANNESS_SELECT];

  // Synchronise the offer toggle; only the second stage is looked at.
  always_ff @(posedge I_LINK_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      offer_s1_q <= 1'b0;
      offer_s2_q <= 1'b0;
    end else begin
      offer_s1_q <= offer_q;
      offer_s2_q <= offer_s1_q;
    end
  end

  // Copy a newly offered bundle. The link clock may stop between frames, in which
  // case the shadow simply keeps the last bundle and the offer waits.
  always_ff @(posedge I_LINK_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      shadow_q <= RESET_BUNDLE;
      taken_q  <= 1'b0;
    end else if (offer_s2_q != taken_q) begin
      shadow_q <= hold_q;
      taken_q  <= offer_s2_q;
    end
  end

  // Configuration registers written by the host; other addresses ignore writes.
  always_ff @(posedge I_LINK_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cfg2_q <= readout_pkg::RST_SENSOR_CONFIG_SECOND;
      cfg5_q <= readout_pkg::RST_SENSOR_CONFIG_FIFTH;
    end else if (i_LINK_WR && !i_LINK_RD && !i_LINK_START) begin
      // A read in the same cycle wins, so the write is dropped then.
      // second configuration register
      if (pointer_q == readout_pkg::ADDR_SENSOR_CONFIG_SECOND) begin
        cfg2_q <= i_LINK_WDATA;
      end
      if (pointer_q == readout_pkg::ADDR_SENSOR_CONFIG_FIFTH) begin
        cfg5_q <= i_LINK_WDATA;
      end
    end
  end

  // Read decode of the addressed byte; unmapped addresses read zero.
  always_comb begin
    read_byte = readout_pkg::UNMAPPED_READ_VALUE;
    case (pointer_q)
      ADDR_EVENT_FLAG_STATUS: begin
        read_byte = shadow_q.event_flags;
      end
      ADDR_TEMPERATURE_VALUE: begin
        read_byte = shadow_q.temperature;
      end
      ADDR_MAGNITUDE_LOW_ADDRESS: begin
        read_byte = low_addr_byte(shadow_q.vector_magnitude, be_sel);
      end
      ADDR_MAGNITUDE_HIGH_ADDRESS: begin
        read_byte = high_addr_byte(shadow_q.vector_magnitude, be_sel);
      end
      ADDR_X_CURRENT_LOW_ADDRESS: begin
        read_byte = low_addr_byte(shadow_q.x_current, be_sel);
      end
      ADDR_X_CURRENT_HIGH_ADDRESS: begin
        read_byte = high_addr_byte(shadow_q.x_current, be_sel);
      end
      ADDR_Y_CURRENT_LOW_ADDRESS: begin
        read_byte = low_addr_byte(shadow_q.y_current, be_sel);
      end
      ADDR_Y_CURRENT_HIGH_ADDRESS: begin
        read_byte = high_addr_byte(shadow_q.y_current, be_sel);
      end
      ADDR_Z_CURRENT_LOW_ADDRESS: begin
        read_byte = low_addr_byte(shadow_q.z_current, be_sel);
      end
      ADDR_Z_CURRENT_HIGH_ADDRESS: begin
        read_byte = high_addr_byte(shadow_q.z_current, be_sel);
      end
      ADDR_FACTORY_RESERVED_ONE: begin
        read_byte = readout_pkg::RST_FACTORY_RESERVED_ONE;
      end
      readout_pkg::ADDR_SAMPLE_STORE_STATUS: begin
        read_byte = {shadow_q.store_watermark, shadow_q.store_overflow, shadow_q.store_count};
      end
      ADDR_STORED_X_LOW_ADDRESS: begin
        read_byte = low_addr_byte(shadow_q.stored_x, be_sel);
      end
      ADDR_STORED_X_HIGH_ADDRESS: begin
        read_byte = high_addr_byte(shadow_q.stored_x, be_sel);
      end
      readout_pkg::ADDR_SENSOR_CONFIG_SECOND: begin
        read_byte = cfg2_q;
      end
      readout_pkg::ADDR_SENSOR_CONFIG_FIFTH: begin
        read_byte = cfg5_q;
      end
      default: begin
        read_byte = readout_pkg::UNMAPPED_READ_VALUE;
      end
    endcase
  end

  // Pointer: loaded by a frame start, advanced after each byte. Start wins over
  // a read or write in the same cycle, because it opens a new frame.
  always_ff @(posedge I_LINK_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pointer_q <= readout_pkg::ADDR_EVENT_FLAG_STATUS;
    end else if (i_LINK_START) begin
      pointer_q <= i_LINK_ADDR;
    end else if (i_LINK_RD) begin
      pointer_q <= next_pointer(pointer_q, cfg2_q, cfg5_q);
    end else if (i_LINK_WR) begin
      // Writes walk the map linearly; skipping only concerns read data.
      pointer_q <= pointer_q + 8'h01;
    end
  end

  // Read data register; holds the last byte until the next read strobe.
  always_ff @(posedge I_LINK_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_q <= readout_pkg::UNMAPPED_READ_VALUE;
    end else if (i_LINK_RD && !i_LINK_START) begin
      rdata_q <= read_byte;
    end
  end

  // All outputs come straight from link-domain flip-flops.
  assign o_LINK_RDATA           = rdata_q;
  assign o_LINK_POINTER         = pointer_q;
  assign o_SENSOR_CONFIG_SECOND = cfg2_q;
  assign o_SENSOR_CONFIG_FIFTH  = cfg5_q;

endmodule

`default_nettype wire

//--- readout_pkg.sv
// Purpose: Shared constants and carrier types for the sensor output register readout.
// Assumes: 8-bit register addresses and 8-bit register data on the link side.
// Notes:   Configuration bit positions are fixed here and used by the readout module.
package readout_pkg;

  // Register addresses of the read-side bank.
  localparam logic [7:0] ADDR_EVENT_FLAG_STATUS     = 8'h00;
  localparam logic [7:0] ADDR_TEMPERATURE_VALUE     = 8'h01;
  localparam logic [7:0] ADDR_MAGNITUDE_LOW_ADDRESS = 8'h02;
  localparam logic [7:0] ADDR_MAGNITUDE_HIGH_ADDRESS = 8'h03;
  localparam logic [7:0] ADDR_X_CURRENT_LOW_ADDRESS = 8'h04;
  localparam logic [7:0] ADDR_X_CURRENT_HIGH_ADDRESS = 8'h05;
  localparam logic [7:0] ADDR_Y_CURRENT_LOW_ADDRESS = 8'h06;
  localparam logic [7:0] ADDR_Y_CURRENT_HIGH_ADDRESS = 8'h07;
  localparam logic [7:0] ADDR_Z_CURRENT_LOW_ADDRESS = 8'h08;
  localparam logic [7:0] ADDR_Z_CURRENT_HIGH_ADDRESS = 8'h09;
  localparam logic [7:0] ADDR_FACTORY_RESERVED_ONE  = 8'h0A;
  localparam logic [7:0] ADDR_SAMPLE_STORE_STATUS   = 8'h0B;
  localparam logic [7:0] ADDR_STORED_X_LOW_ADDRESS  = 8'h0C;
  localparam logic [7:0] ADDR_STORED_X_HIGH_ADDRESS = 8'h0D;
  localparam logic [7:0] ADDR_SENSOR_CONFIG_SECOND  = 8'h16;
  localparam logic [7:0] ADDR_SENSOR_CONFIG_FIFTH   = 8'h19;

  // Reset values.
  localparam logic [7:0] RST_EVENT_FLAG_STATUS    = 8'h01;
  localparam logic [7:0] RST_SAMPLE_STORE_STATUS  = 8'h00;
  localparam logic [7:0] RST_FACTORY_RESERVED_ONE = 8'h00;
  localparam logic [7:0] RST_SENSOR_CONFIG_SECOND = 8'h00;
  localparam logic [7:0] RST_SENSOR_CONFIG_FIFTH  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE      = 8'h00;

  // Field positions inside the second sensor configuration register.
  localparam int BIT_ENDIANNESS_SELECT       = 0;
  localparam int BIT_TEMPERATURE_INCLUDE_BIT = 1;
  localparam int BIT_FAST_READ_ENABLE        = 2;

  // Field positions inside the fifth sensor configuration register.
  localparam int BIT_X_AXIS_DISABLE_BIT   = 0;
  localparam int BIT_Y_AXIS_DISABLE_BIT   = 1;
  localparam int BIT_Z_AXIS_DISABLE_BIT   = 2;
  localparam int BIT_MAGNITUDE_ENABLE_BIT = 3;

  // Field positions inside the sample store status register.
  localparam int BIT_STORE_WATERMARK = 7;
  localparam int BIT_STORE_OVERFLOW  = 6;

  // Number of skip passes the pointer search may take. A linear walk may have
  // to step over 01h to 09h, nine addresses in a row, so eight would stop short.
  localparam int SKIP_PASSES = 12;

  // Everything the sensor core publishes, moved as one word across domains.
  typedef struct packed {
    logic [7:0]  event_flags;
    logic [7:0]  temperature;
    logic [11:0] vector_magnitude;
    logic [11:0] x_current;
    logic [11:0] y_current;
    logic [11:0] z_current;
    logic        store_watermark;
    logic        store_overflow;
    logic [5:0]  store_count;
    logic [11:0] stored_x;
  } sample_bundle_t;

endpackage

//--- readout_monitor.sv
// Purpose: Link-side timing checks on the sensor output register readout bank.
// Assumes: Every strobe and every checked output is sampled on the link clock.
// Notes:   The link clock may stop between frames, so no check counts idle time.
`timescale 1ns/1ns
`default_nettype none
module readout_checker (
  input wire logic       I_LINK_CLK,
  input wire logic       I_RST_N,
  input wire logic       i_LINK_START,
  input wire logic [7:0] i_LINK_ADDR,
  input wire logic       i_LINK_RD,
  input wire logic       i_LINK_WR,
  input wire logic [7:0] i_LINK_WDATA,
  input wire logic [7:0] o_LINK_RDATA,
  input wire logic [7:0] o_LINK_POINTER,
  input wire logic [7:0] o_SENSOR_CONFIG_SECOND,
  input wire logic [7:0] o_SENSOR_CONFIG_FIFTH
);
  default clocking dclk @(posedge I_LINK_CLK); endclocking
  default disable iff (!I_RST_N);
  // A start beats a read, and a read beats a write, in the same cycle.
  wire logic       rd_only = i_LINK_RD && !i_LINK_START;
  wire logic       wr_only = i_LINK_WR && !i_LINK_RD && !i_LINK_START;
  wire logic [7:0] ptr     = o_LINK_POINTER;
  wire logic [7:0] c2      = o_SENSOR_CONFIG_SECOND;
  start_load_a: assert property (i_LINK_START |=> ptr == $past(i_LINK_ADDR))
    else $error("Pointer not loaded by start.");
  idle_pointer_a: assert property (!i_LINK_START && !i_LINK_RD && !i_LINK_WR |=> $stable(ptr))
    else $error("Pointer moved without a strobe.");
  read_hold_a: assert property (!rd_only |=> $stable(o_LINK_RDATA))
    else $error("Read data changed without a read.");
  second_write_a: assert property (wr_only && ptr == 8'h16 |=> c2 == $past(i_LINK_WDATA))
    else $error("Second config write lost.");
  fifth_write_a: assert property (wr_only && ptr == 8'h19 |=> o_SENSOR_CONFIG_FIFTH == $past(i_LINK_WDATA))
    else $error("Fifth config write lost.");
  config_keep_a: assert property (!wr_only |=> $stable(c2) && $stable(o_SENSOR_CONFIG_FIFTH))
    else $error("Config changed without a write.");
  reserved_read_a: assert property (rd_only && ptr == 8'h0A |=> o_LINK_RDATA == 8'h00)
    else $error("Reserved register read not zero.");
  fast_wrap_a: assert property (rd_only && c2[2] && ptr[7:1] == 7'h04 |=> ptr == 8'h00)
    else $error("Fast read did not wrap after the Z pair.");
  temp_skip_a: assert property (rd_only && !c2[1] && ptr == 8'h00 |=> ptr != 8'h01)
    else $error("Temperature not skipped.");
  ro_write_a: assert property (wr_only && ptr <= 8'h0D |=> ptr == $past(ptr) + 8'h01 && $stable(c2))
    else $error("Write to a read-only register misbehaved.");
  cover property (rd_only && ptr == 8'h0D);
  cover property (wr_only && ptr == 8'h19);
  cover property (rd_only && c2[2] && ptr == 8'h08);
endmodule
bind accel_output_register_readout readout_checker u_readout_checker (
  .I_LINK_CLK(I_LINK_CLK), .I_RST_N(I_RST_N), .i_LINK_START(i_LINK_START),
  .i_LINK_ADDR(i_LINK_ADDR), .i_LINK_RD(i_LINK_RD), .i_LINK_WR(i_LINK_WR),
  .i_LINK_WDATA(i_LINK_WDATA), .o_LINK_RDATA(o_LINK_RDATA), .o_LINK_POINTER(o_LINK_POINTER),
  .o_SENSOR_CONFIG_SECOND(o_SENSOR_CONFIG_SECOND), .o_SENSOR_CONFIG_FIFTH(o_SENSOR_CONFIG_FIFTH)
);
`default_nettype wire

//--- link_host.sv
// Purpose: Host model issuing link strobes to the readout bank.
// Assumes: One strobe per operation, held for exactly one link cycle.
// Notes:   Released address and data lines show the inverse of the last value.
`timescale 1ns/1ns
`default_nettype none
module link_host (
  input  wire logic       i_clk,
  output logic            o_start,
  output logic [7:0]      o_addr,
  output logic            o_rd,
  output logic            o_wr,
  output logic [7:0]      o_wdata
);
  initial begin
    {o_start, o_rd, o_wr} = 3'h0;
    {o_addr, o_wdata} = 16'h0000;
  end
  // One operation: raise the strobe after an edge, drop it after the next.
  task automatic op(input logic s, input logic r, input logic w, input logic [7:0] v);
    @(posedge i_clk);
    {o_start, o_rd, o_wr} <= {s, r, w};
    {o_addr, o_wdata} <= {v, v};
    @(posedge i_clk);
    {o_start, o_rd, o_wr} <= 3'h0;
    {o_addr, o_wdata} <= {~v, ~v};
    #1;
  endtask
endmodule
`default_nettype wire

//--- accel_output_register_readout_tb_top.sv
// Purpose: Self-checking bench for the readout bank.
// Assumes: The link clock runs only within frames.
// Notes:   Expected bytes and pointers come from a small model of the map.
`timescale 1ns/1ns
`default_nettype none
module accel_output_register_readout_tb_top;
  logic sclk = 1'b0, lclk = 1'b0, rst_n = 1'b0, run = 1'b1;
  logic [7:0] flags = 8'h01, temp = 8'hA5;
  logic [11:0] mag = 12'h9C3, xv = 12'h1E7, yv = 12'hB42, zv = 12'h6D8, stx = 12'h3F1;
  logic wm = 1'b0, ov = 1'b0;
  logic [5:0] cnt = 6'h00;
  logic start, rd, wr;
  logic [7:0] addr, wdata, rdata, ptr, cfg2, cfg5;
  int fails = 0;
  int check_count = 0;
  accel_output_register_readout DUT (.I_SYS_CLK(sclk), .I_RST_N(rst_n), .I_LINK_CLK(lclk),
    .i_LINK_START(start), .i_LINK_ADDR(addr), .i_LINK_RD(rd), .i_LINK_WR(wr),
    .i_LINK_WDATA(wdata), .i_EVENT_FLAGS(flags), .i_TEMPERATURE(temp),
    .i_VECTOR_MAGNITUDE(mag), .i_X_CURRENT(xv), .i_Y_CURRENT(yv), .i_Z_CURRENT(zv),
    .i_STORE_WATERMARK(wm), .i_STORE_OVERFLOW(ov), .i_STORE_COUNT(cnt), .i_STORED_X(stx),
    .o_LINK_RDATA(rdata), .o_LINK_POINTER(ptr), .o_SENSOR_CONFIG_SECOND(cfg2),
    .o_SENSOR_CONFIG_FIFTH(cfg5));
  link_host host (.i_clk(lclk), .o_start(start), .o_addr(addr), .o_rd(rd), .o_wr(wr),
    .o_wdata(wdata));
  initial begin
    forever #4 sclk = ~sclk;
  end
  // The link clock stands still low whenever no frame is open.
  initial begin
    forever begin
      #7 lclk = run;
      #8 lclk = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] part(input logic [11:0] v, input logic hi, input logic e);
    if (hi) return e ? {4'h0, v[3:0]} : {4'h0, v[11:8]};
    return e ? v[11:4] : v[7:0];
  endfunction
  function automatic logic [7:0] exp_byte(input logic [7:0] a, input logic e);
    case (a)
      8'h00: return flags;
      8'h01: return temp;
      8'h02, 8'h03: return part(mag, a[0], e);
      8'h04, 8'h05: return part(xv, a[0], e);
      8'h06, 8'h07: return part(yv, a[0], e);
      8'h08, 8'h09: return part(zv, a[0], e);
      8'h0B: return {wm, ov, cnt};
      8'h0C, 8'h0D: return part(stx, a[0], e);
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic skipped(input logic [7:0] a, input logic [7:0] c2,
                                   input logic [7:0] c5);
    return (a == 8'h01 && !c2[1]) || (a[7:1] == 7'h01 && !c5[3]) ||
           ((a[7:1] == 7'h02 || a[7:1] == 7'h06) && c5[0]) ||
           (a[7:1] == 7'h03 && c5[1]) || (a[7:1] == 7'h04 && c5[2]);
  endfunction
  // Fast read hops from pair low byte to pair low byte and wraps after Z.
  function automatic logic [7:0] step(input logic [7:0] a, input logic f);
    if (!f || a > 8'h0D || a <= 8'h01 || a == 8'h0A || a == 8'h0B) return a + 8'h01;
    if (a[7:1] == 7'h04) return 8'h00;
    return {a[7:1], 1'b0} + 8'h02;
  endfunction
  function automatic logic [7:0] nxt(input logic [7:0] a, input logic [7:0] c2,
                                     input logic [7:0] c5);
    logic [7:0] n;
    n = step(a, c2[2]);
    repeat (12) if (skipped(n, c2, c5)) n = step(n, c2[2]);
    return n;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic setcfg(input logic [7:0] c2, input logic [7:0] c5);
    host.op(1'b1, 1'b0, 1'b0, 8'h16);
    host.op(1'b0, 1'b0, 1'b1, c2);
    check(cfg2, c2);
    check(ptr, 8'h17);
    host.op(1'b1, 1'b0, 1'b0, 8'h19);
    host.op(1'b0, 1'b0, 1'b1, c5);
    check(cfg5, c5);
  endtask
  // Open a frame, configure, then read n bytes from st checking data and pointer.
  task automatic walk(input logic [7:0] c2, input logic [7:0] c5, input logic [7:0] st,
                      input int n);
    logic [7:0] p;
    run = 1'b1;
    repeat (8) @(posedge lclk);
    setcfg(c2, c5);
    host.op(1'b1, 1'b0, 1'b0, st);
    p = st;
    repeat (n) begin
      host.op(1'b0, 1'b1, 1'b0, 8'h00);
      check(rdata, exp_byte(p, c2[0]));
      p = nxt(p, c2, c5);
      check(ptr, p);
    end
    run = 1'b0;
  endtask
  task automatic t_reset;
    check(cfg2, 8'h00);
    check(ptr, 8'h00);
    walk(8'h00, 8'h00, 8'h0A, 2);
    walk(8'h00, 8'h00, 8'h00, 1);
  endtask
  task automatic t_slow;
    @(posedge sclk);
    flags <= 8'h5C;
    wm <= 1'b1;
    cnt <= 6'h2A;
    walk(8'h02, 8'h08, 8'h00, 14);
    walk(8'h03, 8'h08, 8'h00, 14);
  endtask
  task automatic t_skips;
    walk(8'h00, 8'h07, 8'h00, 4);
    walk(8'h02, 8'h02, 8'h00, 5);
    walk(8'h02, 8'h0C, 8'h06, 3);
  endtask
  task automatic t_fast;
    walk(8'h06, 8'h08, 8'h00, 7);
    walk(8'h05, 8'h09, 8'h03, 4);
  endtask
  // A write below the config registers only moves the pointer.
  task automatic t_refuse;
    walk(8'h06, 8'h08, 8'h05, 0);
    run = 1'b1;
    host.op(1'b0, 1'b0, 1'b1, 8'hFF);
    check(ptr, 8'h06);
    check(cfg2, 8'h06);
    check(cfg5, 8'h08);
    run = 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge sclk);
    rst_n <= 1'b1;
    t_reset();
    t_slow();
    t_skips();
    t_fast();
    t_refuse();
    end_of_test();
  end
  // A hung run counts as a mismatch.
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
